// *** hdl/sfp_pkg.sv ***
// package for the switch fault protection block: register map, fields, timing
// assumes a plain strobe register port and a 50 MHz device clock
package sfp_pkg;
    // register offsets
    localparam logic [3:0] ADDR_GLOBAL   = 4'h0; // global_settings_register
    localparam logic [3:0] ADDR_STATUS   = 4'h1; // status_register, read clears warnings
    localparam logic [3:0] ADDR_FAULT0   = 4'h2; // channel 0 fault register
    localparam logic [3:0] ADDR_FAULT1   = 4'h3; // channel 1 fault register
    localparam logic [3:0] ADDR_CTRL     = 4'h4; // on-requests, delatch, retry enables
    localparam logic [3:0] ADDR_WIN      = 4'h5; // window widths ch0 [15:0] ch1 [31:16]
    // global fields
    localparam int GS_GUARD_OFF  = 0;            // supply_high_guard_off
    localparam int GS_LOAD0      = 1;            // load_type_select ch0 (1 = motor)
    localparam int GS_LOAD1      = 2;            // load_type_select ch1
    localparam logic [31:0] GS_RESET = 32'h0000_0000;
    // status fields
    localparam int ST_HIGH  = 0;                 // supply_high_flag
    localparam int ST_LOW   = 1;                 // supply_low_flag
    localparam int ST_SWM0  = 2;                 // switch mode ch0
    localparam int ST_SWM1  = 3;                 // switch mode ch1
    localparam int ST_FSN   = 4;                 // fault_status_n mirror
    // per-channel fault fields
    localparam int FL_OC    = 0;                 // excess_current_flag
    localparam int FL_SC    = 1;                 // short_circuit_flag
    localparam int FL_OT    = 2;                 // thermal_trip_flag
    localparam int FL_OL    = 3;                 // open load (load ground loss)
    // control fields
    localparam int CT_ON0   = 0;                 // high_side_on_request ch0
    localparam int CT_ON1   = 1;                 // high_side_on_request ch1
    localparam int CT_DL0   = 2;                 // delatch ch0 (write 1, self clearing)
    localparam int CT_DL1   = 3;                 // delatch ch1
    localparam int CT_RT0   = 4;                 // auto-retry enable ch0
    localparam int CT_RT1   = 5;                 // auto-retry enable ch1
    localparam logic [15:0] WIN_RESET = 16'h00ff; // default window width, cycles
    // fast turn-off time and auto-retry period
    localparam int T_FAULT_NS   = 20;
    localparam int CLK_NS       = 20;
    localparam int FAULT_CYC    = (T_FAULT_NS + CLK_NS - 1) / CLK_NS;
    localparam int RETRY_US     = 1000;
    localparam int RETRY_CYC    = RETRY_US * 1000 / CLK_NS;
    // comparator and supply inputs carried together
    typedef struct packed {
        logic       ov;   // supply at or above overvoltage threshold
        logic       ov_clr; // supply below threshold minus hysteresis
        logic       uv;   // supply below undervoltage threshold
        logic       xlow; // supply below low extended limit
        logic       logic_fail; // logic supply failed, power supply normal
        logic       por;  // both supplies below power-on threshold
        logic       sys_gnd_loss;
        logic       gnd_high; // device ground at logic high
    } sfp_supply_t;
    typedef struct packed {
        logic       oc_seg;  // current in active window segment
        logic       oc_cross; // threshold crossed
        logic       sc;      // severe short at turn-on
        logic       ot;      // overtemperature
        logic       load_gnd_loss;
        logic       pwm;     // pwm activity above min frequency
        logic       full_on; // duty at 100 %
    } sfp_chan_t;
    typedef enum logic [1:0] {
        SFP_OFF,
        SFP_ON,
        SFP_LATCHED,
        SFP_RETRY
    } sfp_state_t;
endpackage

// *** hdl/sfp_top.sv ***
// two-channel fault protection: duration counters, latched faults, supply guards
// assumes comparator inputs are asynchronous and pass a two-stage synchroniser;
// register strobes come from logic on mclk_i
//
// Notes on behaviour
// - switch mode: duty below full, pwm running
// - count only segment time during on-times
// - trip overcurrent once count exceeds window
// - delatch clears count; lighting retry clears too
// - motor: clean on-period clears at turn-off
// - pwm edges alone never clear count
// - severe short: off, flag, latch, retry
// - overvoltage: both off, pin low, flag
// - off until hysteresis; flag clears on read
// - guard off: flag only, no shutdown
// - undervoltage: off, pin low, shared flag
// - uv ends idle: pin high, flag kept
// - uv ends requested: needs delatch; read clears
// - auto-retry starts once undervoltage ends
// - extended range keeps settings and faults
// - below low limit only thermal acts
// - latched faults cleared by supply loss, read
// - fault turn-off bypasses slew rate
// - load gnd loss: open load; system: off
// - ground high: port stops, fail-safe
// - lighting profile armed at first turn-on
//
// The plain strobed port and the address map were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
module sfp_top #(
    parameter int CNT_W     = 16,                       // duration counter width
    parameter int RETRY_CYC = sfp_pkg::RETRY_CYC        // auto-retry period
) (
    input  wire logic                 mclk_i,           // 50 MHz clock
    input  wire logic                 rst_i,            // sync reset, high
    input  wire sfp_pkg::sfp_supply_t supply_i,         // supply comparators, async
    input  wire sfp_pkg::sfp_chan_t   chan0_i,          // ch0 comparators, async
    input  wire sfp_pkg::sfp_chan_t   chan1_i,          // ch1 comparators, async
    input  wire logic                 in0_i,            // direct input ch0, fail-safe
    input  wire logic                 in1_i,            // direct input ch1, fail-safe
    input  wire logic [3:0]           addr_i,           // register address
    input  wire logic [31:0]          wdata_i,          // write data
    input  wire logic                 wr_i,             // write strobe
    input  wire logic                 rd_i,             // read strobe
    output logic      [31:0]          rdata_o,          // read data, next cycle
    output logic      [1:0]           gate_o,           // channel gate enables
    output logic      [1:0]           fast_off_o,       // slew bypass on fault off
    output logic                      fault_status_n_o, // fault pin, low active
    output logic                      failsafe_o        // fail-safe mode
);
    ////////////////////////////////////////////////////////////////////////////
    // synchronisers: stage one feeds only stage two
    localparam int SW = $bits(sfp_pkg::sfp_supply_t);
    localparam int CW = $bits(sfp_pkg::sfp_chan_t);
    logic [SW-1:0]  sup_m, sup_s;
    logic [CW-1:0]  ch_m [2], ch_s [2];
    logic [1:0]     in_m, in_s;
    sfp_pkg::sfp_supply_t sup;
    always_ff @(posedge mclk_i) begin
        sup_m <= supply_i;
        sup_s <= sup_m;
        ch_m[0] <= chan0_i;
        ch_m[1] <= chan1_i;
        ch_s[0] <= ch_m[0];
        ch_s[1] <= ch_m[1];
        in_m  <= {in1_i, in0_i};
        in_s  <= in_m;
    end
    assign sup = sup_s;

    ////////////////////////////////////////////////////////////////////////////
    // registers
    logic [31:0] gsr, ctrl, win;
    logic        high_flag, low_flag;
    logic [3:0]  fault [2];
    logic [1:0]  swm;
    logic        rd_status, rd_f0, rd_f1, wr_ctrl;
    logic [1:0]  delatch;
    // port stops answering with ground lifted
    assign rd_status = rd_i && addr_i == sfp_pkg::ADDR_STATUS && !sup.gnd_high;
    assign rd_f0     = rd_i && addr_i == sfp_pkg::ADDR_FAULT0 && !sup.gnd_high;
    assign rd_f1     = rd_i && addr_i == sfp_pkg::ADDR_FAULT1 && !sup.gnd_high;
    assign wr_ctrl   = wr_i && addr_i == sfp_pkg::ADDR_CTRL && !sup.gnd_high;
    assign delatch   = wr_ctrl ? wdata_i[sfp_pkg::CT_DL1:sfp_pkg::CT_DL0] : 2'h0;

    // settings survive extended range; only reset, logic-supply loss or por wipes them
    always_ff @(posedge mclk_i) begin
        if (rst_i || sup.por || sup.logic_fail) begin
            gsr  <= sfp_pkg::GS_RESET;
            ctrl <= 32'h0;
            win  <= {sfp_pkg::WIN_RESET, sfp_pkg::WIN_RESET};
        end else if (wr_i && !sup.gnd_high) begin
            if (addr_i == sfp_pkg::ADDR_GLOBAL) gsr <= wdata_i;
            if (addr_i == sfp_pkg::ADDR_CTRL) ctrl <= wdata_i & 32'hffff_fff3;
            if (addr_i == sfp_pkg::ADDR_WIN) win <= wdata_i;
        end
    end

    // read mux, unmapped reads zero
    always_ff @(posedge mclk_i) begin
        if (rst_i) begin
            rdata_o <= 32'h0;
        end else begin
            rdata_o <= 32'h0;
            if (rd_i && !sup.gnd_high) begin
                case (addr_i)
                    sfp_pkg::ADDR_GLOBAL: rdata_o <= gsr;
                    sfp_pkg::ADDR_STATUS: rdata_o <= {27'h0, fault_status_n_o, swm,
                                                      low_flag, high_flag};
                    sfp_pkg::ADDR_FAULT0: rdata_o <= {28'h0, fault[0]};
                    sfp_pkg::ADDR_FAULT1: rdata_o <= {28'h0, fault[1]};
                    sfp_pkg::ADDR_CTRL:   rdata_o <= ctrl;
                    sfp_pkg::ADDR_WIN:    rdata_o <= win;
                    default:              rdata_o <= 32'h0;
                endcase
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // supply guards
    logic ov_hold, uv_seen, guard_off, any_on;
    assign guard_off = gsr[sfp_pkg::GS_GUARD_OFF];
    always_ff @(posedge mclk_i) begin
        if (rst_i || sup.por || sup.logic_fail) begin
            ov_hold   <= 1'b0;
            high_flag <= 1'b0;
        end else begin
            // shutdown hold ends below threshold minus hysteresis, or at once with guard off
            if (sup.ov && !guard_off) ov_hold <= 1'b1;
            else if (sup.ov_clr || guard_off) ov_hold <= 1'b0;
            // set wins over the read clear; warning set even with guard off
            if (sup.ov) high_flag <= 1'b1;
            else if (rd_status && !ov_hold) high_flag <= 1'b0;
        end
    end
    always_ff @(posedge mclk_i) begin
        if (rst_i || sup.por || sup.logic_fail) begin
            low_flag <= 1'b0;
            uv_seen  <= 1'b0;
        end else begin
            if (sup.uv) begin
                low_flag <= 1'b1;
                uv_seen  <= 1'b1;
            end else begin
                // warning drops at first turn-on, else on status read
                if (any_on || (rd_status && !uv_seen)) low_flag <= 1'b0;
                if (delatch != 2'h0) uv_seen <= 1'b0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // per-channel protection
    logic [1:0] ch_on, latched;
    genvar g;
    generate
        for (g = 0; g < 2; g++) begin : g_ch
            sfp_pkg::sfp_chan_t c;
            sfp_pkg::sfp_state_t st;
            logic [CNT_W-1:0] dur;
            logic [$clog2(RETRY_CYC+1)-1:0] rcnt;
            logic req, motor, retry_en, on_prev, seen_oc, armed, trip, gnd_off;
            logic [CNT_W-1:0] width;
            // local names for the channel states, nothing is imported
            localparam sfp_pkg::sfp_state_t SFP_OFF     = sfp_pkg::SFP_OFF;
            localparam sfp_pkg::sfp_state_t SFP_ON      = sfp_pkg::SFP_ON;
            localparam sfp_pkg::sfp_state_t SFP_LATCHED = sfp_pkg::SFP_LATCHED;
            localparam sfp_pkg::sfp_state_t SFP_RETRY   = sfp_pkg::SFP_RETRY;
            assign c        = ch_s[g];
            assign motor    = gsr[sfp_pkg::GS_LOAD0 + g];
            assign retry_en = ctrl[sfp_pkg::CT_RT0 + g];
            // ground lifted: direct inputs take over
            assign req      = sup.gnd_high ? in_s[g] : ctrl[sfp_pkg::CT_ON0 + g];
            assign width    = win[g*16 +: CNT_W];
            assign trip     = c.oc_cross || (dur > width);
            // supply faults force off; below low limit only thermal acts
            // raw overvoltage too, so both gates drop in the same cycle
            assign gnd_off  = sup.sys_gnd_loss || ov_hold || sup.uv ||
                              (sup.ov && !guard_off);
            // switch mode flag
            always_ff @(posedge mclk_i) begin
                if (rst_i) swm[g] <= 1'b0;
                else swm[g] <= c.pwm && !c.full_on;
            end
            // duration counter
            always_ff @(posedge mclk_i) begin
                if (rst_i || delatch[g]) begin
                    dur     <= '0;
                    seen_oc <= 1'b0;
                    armed   <= 1'b0;
                end else begin
                    if (st == SFP_ON && !on_prev) armed <= 1'b1;
                    if (st == SFP_ON) begin
                        // off-times never count
                        if (c.oc_seg && dur != '1) dur <= dur + 1'b1;
                        if (c.oc_seg) seen_oc <= 1'b1;
                    end
                    if (on_prev && st != SFP_ON) begin
                        seen_oc <= 1'b0;
                        if (motor && !seen_oc) dur <= '0;
                    end
                    // lighting retry gives a fresh inrush budget
                    if (st == SFP_RETRY && rcnt == '0 && !motor) begin
                        dur   <= '0;
                        armed <= swm[g] ? armed : 1'b0;
                    end
                end
            end
            // channel state machine
            always_ff @(posedge mclk_i) begin
                if (rst_i) begin
                    st      <= SFP_OFF;
                    on_prev <= 1'b0;
                    rcnt    <= '0;
                end else begin
                    on_prev <= st == SFP_ON;
                    case (st)
                        SFP_OFF: begin
                            if (req && !gnd_off && !uv_seen && !c.ot) st <= SFP_ON;
                        end
                        SFP_ON: begin
                            if (!req || gnd_off) st <= SFP_OFF;
                            if (!sup.xlow && (trip || c.sc) || c.ot || sup.uv) begin
                                st   <= retry_en ? SFP_RETRY : SFP_LATCHED;
                                rcnt <= ($clog2(RETRY_CYC+1))'(RETRY_CYC);
                            end
                        end
                        SFP_RETRY: begin
                            // retry waits until uv and overtemperature are gone
                            if (!sup.uv && !c.ot && rcnt != '0) rcnt <= rcnt - 1'b1;
                            if (rcnt == '0) st <= req ? SFP_ON : SFP_OFF;
                            if (delatch[g]) st <= SFP_OFF;
                        end
                        SFP_LATCHED: begin
                            if (delatch[g]) st <= SFP_OFF;
                        end
                        default: st <= SFP_OFF;
                    endcase
                end
            end
            // fault flags: set wins, read clears in any state but SFP_LATCHED; open load reloads its cause
            always_ff @(posedge mclk_i) begin
                if (rst_i || sup.por || sup.logic_fail) begin
                    fault[g] <= 4'h0;
                end else begin
                    if ((g == 0 ? rd_f0 : rd_f1) && st != SFP_LATCHED) begin
                        fault[g][sfp_pkg::FL_OC] <= 1'b0;
                        fault[g][sfp_pkg::FL_SC] <= 1'b0;
                        fault[g][sfp_pkg::FL_OT] <= 1'b0;
                        fault[g][sfp_pkg::FL_OL] <= c.load_gnd_loss;
                    end
                    if (st == SFP_ON && !sup.xlow && trip) fault[g][sfp_pkg::FL_OC] <= 1'b1;
                    if (st == SFP_ON && !sup.xlow && c.sc) fault[g][sfp_pkg::FL_SC] <= 1'b1;
                    // thermal trip reported once supply back above uv
                    if (c.ot && !sup.uv) fault[g][sfp_pkg::FL_OT] <= 1'b1;
                    if (c.load_gnd_loss) fault[g][sfp_pkg::FL_OL] <= 1'b1;
                end
            end
            assign ch_on[g]   = st == SFP_ON && !gnd_off && !c.ot &&
                                !(trip && !sup.xlow) && !(c.sc && !sup.xlow);
            assign latched[g] = st == SFP_LATCHED || st == SFP_RETRY;
            // gate and fast turn-off straight from flops
            always_ff @(posedge mclk_i) begin
                if (rst_i) begin
                    gate_o[g]     <= 1'b0;
                    fast_off_o[g] <= 1'b0;
                end else begin
                    gate_o[g]     <= ch_on[g];
                    fast_off_o[g] <= st == SFP_ON && !ch_on[g] && req;
                end
            end
            a_trip_off: assert property (@(posedge mclk_i) disable iff (rst_i)
                (st == SFP_ON && c.sc && !sup.xlow) |=> !gate_o[g])
                else $error("gate stayed on after severe short");
            a_fast_off: assert property (@(posedge mclk_i) disable iff (rst_i)
                (st == SFP_ON && req && sup.uv) |=> fast_off_o[g])
                else $error("fault turn-off not fast");
            a_dur_hold: assert property (@(posedge mclk_i) disable iff (rst_i)
                (st == SFP_OFF && !delatch[g] && !on_prev) |=> $stable(dur))
                else $error("duration counted during off-time");
        end
    endgenerate
    assign any_on = |ch_on;

    ////////////////////////////////////////////////////////////////////////////
    // fault pin and fail-safe
    always_ff @(posedge mclk_i) begin
        if (rst_i) begin
            fault_status_n_o <= 1'b1;
            failsafe_o       <= 1'b0;
        end else begin
            fault_status_n_o <= !(|latched || (sup.ov && !guard_off) || sup.uv
                                  || ov_hold);
            failsafe_o       <= sup.gnd_high;
        end
    end

    sequence s_ov;
        sup.ov && !guard_off;
    endsequence
    a_ov_pin: assert property (@(posedge mclk_i) disable iff (rst_i)
        s_ov |=> !fault_status_n_o && gate_o == 2'h0)
        else $error("overvoltage did not shut down");
    a_ov_guard: assert property (@(posedge mclk_i) disable iff (rst_i)
        (sup.ov && guard_off && !sup.uv && latched == 2'h0) |=> fault_status_n_o)
        else $error("guard off still pulled pin low");
    a_ov_flag: assert property (@(posedge mclk_i) disable iff (rst_i || sup.por || sup.logic_fail)
        sup.ov |=> high_flag)
        else $error("supply high flag missing");
    a_uv_off: assert property (@(posedge mclk_i) disable iff (rst_i)
        sup.uv |=> gate_o == 2'h0 && !fault_status_n_o)
        else $error("undervoltage left channel on");
    a_latch_pin: assert property (@(posedge mclk_i) disable iff (rst_i)
        (latched != 2'h0) |=> !fault_status_n_o)
        else $error("latched fault without pin low");
endmodule // sfp_top
`default_nettype wire

// *** tb/sfp_host.sv ***
// host model: drives the register port, notes expected read data
// assumes the caller sits at a rising edge of mclk_i
`timescale 1ns/1ps
`default_nettype none
module sfp_host (
    input  wire logic        mclk_i,  // device clock
    output logic      [3:0]  addr_o,  // register address
    output logic      [31:0] wdata_o, // write data
    output logic             wr_o,    // write strobe
    output logic             rd_o     // read strobe
);
    logic [63:0] exp_q[$]; // {mask, expected} per read
    initial begin
        addr_o = '0;
        wdata_o = '0;
        wr_o = 1'b0;
        rd_o = 1'b0;
    end
    // one-cycle write; a gap cycle keeps strobes single-driven per step
    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        @(posedge mclk_i);
        addr_o  <= a;
        wdata_o <= d;
        wr_o    <= 1'b1;
        @(posedge mclk_i);
        wr_o    <= 1'b0;
    endtask
    // one-cycle read; data is judged by the bench monitor a cycle later
    task automatic rd(input logic [3:0] a, input logic [31:0] m, input logic [31:0] e);
        @(posedge mclk_i);
        addr_o <= a;
        rd_o   <= 1'b1;
        exp_q.push_back({m, e});
        @(posedge mclk_i);
        rd_o   <= 1'b0;
    endtask
    // delatch and ask for turn-on in one write after a supply dip
    task automatic relatch_on();
        wr(sfp_pkg::ADDR_CTRL, 32'h0000_000f);
    endtask
endmodule // sfp_host
`default_nettype wire

// *** tb/tb_switch_fault_protection.sv ***
// bench for sfp_top: supply and channel faults, register port, fail-safe
// assumes the host model drives all register traffic
`timescale 1ns/1ps
`default_nettype none
module tb_switch_fault_protection;
    logic mclk_i = 1'b0;
    logic rst_i = 1'b1;
    sfp_pkg::sfp_supply_t sup = '0;
    sfp_pkg::sfp_chan_t c0 = '0;
    sfp_pkg::sfp_chan_t c1 = '0;
    logic [3:0] addr;
    logic [31:0] wdata, rdata, w;
    logic wr, rd, rd_d = 1'b0, fault_n, failsafe, fo_seen = 1'b0, in0 = 1'b0;
    logic [1:0] gate, fast_off;
    logic [63:0] ent;
    int miscompares = 0, samples_checked = 0;
    int seed = 32'hbac08c35;
    always #10 mclk_i = ~mclk_i;
    ////////////////////////////////////////////////////////////////////////
    sfp_host i_host (.mclk_i(mclk_i), .addr_o(addr), .wdata_o(wdata), .wr_o(wr), .rd_o(rd));
    sfp_top #(.CNT_W(16), .RETRY_CYC(8)) i_dut (
        .mclk_i(mclk_i), .rst_i(rst_i), .supply_i(sup), .chan0_i(c0), .chan1_i(c1),
        .in0_i(in0), .in1_i(1'b0), .addr_i(addr), .wdata_i(wdata), .wr_i(wr),
        .rd_i(rd), .rdata_o(rdata), .gate_o(gate), .fast_off_o(fast_off),
        .fault_status_n_o(fault_n), .failsafe_o(failsafe));
    task automatic chk(input logic [31:0] seen, input logic [31:0] e, input string nm);
        samples_checked++;
        if (seen !== e) begin
            miscompares++;
            $display("CHECK FAILED %s expected %h seen %h", nm, e, seen);
        end
    endtask
    task automatic end_sim();
        $display("checks %0d mismatches %0d", samples_checked, miscompares);
        if (miscompares == 0 && samples_checked > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    // read monitor: data stands only in the cycle after the strobe
    always @(posedge mclk_i) begin
        if (rd_d) begin
            ent = i_host.exp_q.pop_front();
            chk(rdata & ent[63:32], ent[31:0], "rdata");
        end
        rd_d <= rd;
        if (fast_off[0]) fo_seen <= 1'b1; // pulse may be one cycle only
    end
    task automatic do_rst();
        rst_i <= 1'b1;
        sup <= '0;
        c0 <= '0;
        c1 <= '0;
        repeat (10) @(posedge mclk_i);
        rst_i <= 1'b0;
    endtask
    task automatic on_both();
        i_host.wr(sfp_pkg::ADDR_CTRL, 32'h0000_0003);
        repeat (5) @(posedge mclk_i);
        chk({30'h0, gate}, 32'h3, "gate_on");
    endtask
    // watchdog, far beyond the expected run length
    initial begin
        repeat (5000) @(posedge mclk_i);
        miscompares++;
        end_sim();
    end
    ////////////////////////////////////////////////////////////////////////
    initial begin
        do_rst();
        chk({29'h0, gate, fault_n}, 32'h1, "reset_pins");
        i_host.rd(sfp_pkg::ADDR_GLOBAL, '1, sfp_pkg::GS_RESET);
        i_host.rd(sfp_pkg::ADDR_WIN, '1, {sfp_pkg::WIN_RESET, sfp_pkg::WIN_RESET});
        i_host.rd(4'hf, '1, 32'h0);
        w = $random(seed);
        i_host.wr(sfp_pkg::ADDR_WIN, w);
        i_host.rd(sfp_pkg::ADDR_WIN, '1, w);
        // overcurrent: four-cycle window, trip once exceeded, ch1 unaffected
        i_host.wr(sfp_pkg::ADDR_WIN, 32'h0004_0004);
        on_both();
        c0.oc_seg <= 1'b1;
        c0.full_on <= 1'b1;
        repeat (3) @(posedge mclk_i);
        chk({30'h0, gate}, 32'h3, "gate_in_window");
        repeat (12) @(posedge mclk_i);
        chk({29'h0, gate, fault_n}, 32'h4, "gate_oc");
        chk({31'h0, fo_seen}, 32'h1, "fast_off");
        i_host.rd(sfp_pkg::ADDR_FAULT0, 32'h1, 32'h1);
        // severe short on ch1 while it is on
        c1.sc <= 1'b1;
        repeat (5) @(posedge mclk_i);
        chk({30'h0, gate}, 32'h0, "gate_sc");
        i_host.rd(sfp_pkg::ADDR_FAULT1, 32'h2, 32'h2);
        // guard off: flag only
        do_rst();
        i_host.wr(sfp_pkg::ADDR_GLOBAL, 32'h1);
        on_both();
        sup.ov <= 1'b1;
        repeat (5) @(posedge mclk_i);
        chk({29'h0, gate, fault_n}, 32'h7, "guard_off");
        i_host.rd(sfp_pkg::ADDR_STATUS, 32'h1, 32'h1);
        // overvoltage with guard: both off, flag clears by read once gone
        do_rst();
        on_both();
        sup.ov <= 1'b1;
        repeat (5) @(posedge mclk_i);
        chk({29'h0, gate, fault_n}, 32'h0, "ov_off");
        sup.ov <= 1'b0;
        sup.ov_clr <= 1'b1;
        repeat (5) @(posedge mclk_i);
        i_host.rd(sfp_pkg::ADDR_STATUS, 32'h1, 32'h1);
        i_host.rd(sfp_pkg::ADDR_STATUS, 32'h1, 32'h0);
        // undervoltage
        do_rst();
        on_both();
        sup.uv <= 1'b1;
        repeat (5) @(posedge mclk_i);
        chk({29'h0, gate, fault_n}, 32'h0, "uv_off");
        i_host.rd(sfp_pkg::ADDR_STATUS, 32'h2, 32'h2);
        sup.uv <= 1'b0;
        repeat (3) @(posedge mclk_i); // let the synchroniser see uv gone
        i_host.relatch_on();
        // ground high: fail-safe, direct inputs steer, port reads zero
        sup.gnd_high <= 1'b1;
        in0 <= 1'b1;
        repeat (5) @(posedge mclk_i);
        chk({31'h0, failsafe}, 32'h1, "failsafe");
        chk({30'h0, gate}, 32'h1, "failsafe_gate");
        i_host.rd(sfp_pkg::ADDR_GLOBAL, '1, 32'h0);
        repeat (3) @(posedge mclk_i);
        end_sim();
    end
endmodule // tb_switch_fault_protection
`default_nettype wire
